// ===== smcg_pkg.sv
// Purpose: Shared constants and types for the sleep mode clock gating block.
// Assumes: One system clock; all inputs synchronous to it.
// Notes:   Mode codes, control port offsets and wake timing live here.
`default_nettype none
package smcg_pkg;
   // ==========================================================
   // Sleep mode select encodings.
   localparam logic [2:0] SMCG_MODE_IDLE   = 3'h0;
   localparam logic [2:0] SMCG_MODE_ADCNR  = 3'h1;
   localparam logic [2:0] SMCG_MODE_PDOWN  = 3'h2;
   localparam logic [2:0] SMCG_MODE_PSAVE  = 3'h3;
   localparam logic [2:0] SMCG_MODE_STBY   = 3'h6;
   localparam logic [2:0] SMCG_MODE_XSTBY  = 3'h7;
   // ==========================================================
   // Register offsets on the plain control port.
   localparam logic [3:0] SMCG_OFS_MCU_CTRL   = 4'h0;
   localparam logic [3:0] SMCG_OFS_ASYNC_STAT = 4'h1;
   localparam logic [3:0] SMCG_OFS_MCU_CSR    = 4'h2;
   localparam logic [3:0] SMCG_OFS_STATUS     = 4'h3;
   // Field positions.
   localparam int SMCG_BIT_SE    = 5;
   localparam int SMCG_BIT_SM_LO = 2;
   localparam int SMCG_BIT_AS0   = 3;
   localparam int SMCG_BIT_JTD   = 7;
   localparam logic [7:0] SMCG_RESET_BYTE = 8'h00;
   // ==========================================================
   // Wake timing in cycles of the running oscillator.
   localparam int SMCG_STBY_WAKE_CYC = 6;
   localparam int SMCG_HALT_EXTRA    = 4;
   localparam logic [7:0] SMCG_CNT_ONE = 8'h01;
   // Clock domain enables carried together.
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic asy;
      logic main_osc;
      logic timer_osc;
   } smcg_clk_type;
   // Wake source classes.
   typedef struct packed {
      logic ext_int;
      logic twi_match;
      logic timer0;
      logic spm_ee;
      logic adc;
      logic other_io;
   } smcg_wake_type;
   typedef enum logic [1:0] {
      SMCG_RUN   = 2'b00,
      SMCG_SLEEP = 2'b01,
      SMCG_START = 2'b10,
      SMCG_HALT  = 2'b11
   } smcg_state_type;
endpackage
`default_nettype wire

// ===== smcg_sleep_ctrl.sv
// Purpose: Sleep controller gating clock domains and wake sources per sleep mode.
// Assumes: Core pulses sleep_req on a sleep instruction; inputs are synchronous.
// Notes:   Start-up time for non-standby modes is a parameter in cycles.
`timescale 1ns/1ps
`default_nettype none
module smcg_sleep_ctrl #(
   parameter int STARTUP_CYC = 16
) (
   // System.
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Register port.
   input  wire logic [3:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output var  logic [7:0]             reg_rdata,
   // Core handshake.
   input  wire logic                   sleep_req,
   output var  logic                   core_halt,
   // Fuses and straps.
   input  wire logic                   ext_crystal_sel,
   input  wire logic                   brownout_enable_fuse,
   input  wire logic                   debug_enable_fuse,
   input  wire logic                   scan_port_enable_fuse,
   // Peripheral state.
   input  wire logic                   adc_enable,
   input  wire logic                   comp_disable,
   input  wire logic                   comp_uses_ref,
   input  wire logic                   watchdog_enable,
   // Wake events.
   input  wire logic [7:0]             external_interrupt_lines,
   input  wire logic [7:4]             ext_level_mode,
   input  wire smcg_pkg::smcg_wake_type wake_evt,
   // Gated outputs.
   output var  smcg_pkg::smcg_clk_type clk_en,
   output var  logic                   adc_run,
   output var  logic                   adc_extended_conv,
   output var  logic                   comp_run,
   output var  logic                   ref_enable,
   output var  logic                   brownout_run,
   output var  logic                   watchdog_run,
   output var  logic                   input_buf_en,
   output var  logic [7:0]             wake_pin_buf_en
);
   import smcg_pkg::*;

   // ==========================================================
   // Control registers.
   logic [7:0]     mcu_control_reg_r;
   logic           async_timer_clock_select_r;
   logic           scan_port_disable_bit_r;
   smcg_state_type state_r;
   logic [2:0]     mode_r;
   logic [7:0]     cnt_r;
   logic           adc_prev_r;
   logic           in_sleep;
   logic           mode_ok;
   logic           debug_active;
   logic           wake_any;
   logic [2:0]     sel_mode;
   logic           stby_mode;
   smcg_clk_type   clk_nxt;
   smcg_wake_type  wake_ok;
   logic [7:0]     wake_pin_nxt;

   assign sel_mode  = mcu_control_reg_r[SMCG_BIT_SM_LO +: 3];
   assign in_sleep  = (state_r == SMCG_SLEEP);
   assign stby_mode = (mode_r == SMCG_MODE_STBY) || (mode_r == SMCG_MODE_XSTBY);

   // Software writes to control bytes; jtd bit lives in the control-status byte.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mcu_control_reg_r          <= SMCG_RESET_BYTE;
         async_timer_clock_select_r <= 1'b0;
         scan_port_disable_bit_r    <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == SMCG_OFS_MCU_CTRL) begin
            mcu_control_reg_r <= reg_wdata;
         end
         if (reg_addr == SMCG_OFS_ASYNC_STAT) begin
            async_timer_clock_select_r <= reg_wdata[SMCG_BIT_AS0];
         end
         if (reg_addr == SMCG_OFS_MCU_CSR) begin
            scan_port_disable_bit_r <= reg_wdata[SMCG_BIT_JTD];
         end
      end
   end

   // Read data stands one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= SMCG_RESET_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            SMCG_OFS_MCU_CTRL:   reg_rdata <= mcu_control_reg_r;
            SMCG_OFS_ASYNC_STAT: reg_rdata <= {4'h0, async_timer_clock_select_r, 3'h0};
            SMCG_OFS_MCU_CSR:    reg_rdata <= {scan_port_disable_bit_r, 7'h00};
            SMCG_OFS_STATUS:     reg_rdata <= {3'h0, mode_r, state_r};
            default:             reg_rdata <= SMCG_RESET_BYTE;
         endcase
      end else begin
         reg_rdata <= SMCG_RESET_BYTE;
      end
   end

   // ==========================================================
   // Mode legality: standby variants need a crystal, reserved codes are refused.
   always_comb begin
      case (sel_mode)
         SMCG_MODE_IDLE, SMCG_MODE_ADCNR,
         SMCG_MODE_PDOWN, SMCG_MODE_PSAVE: mode_ok = 1'b1;
         SMCG_MODE_STBY, SMCG_MODE_XSTBY:  mode_ok = ext_crystal_sel;
         default:                          mode_ok = 1'b0;
      endcase
   end

   // Debug is live only while both fuses are set and the disable bit is clear.
   assign debug_active = debug_enable_fuse && scan_port_enable_fuse
                         && !scan_port_disable_bit_r;

   // Per-mode clock enables while asleep.
   always_comb begin
      clk_nxt = '{default: 1'b1};
      if (in_sleep) begin
         clk_nxt = '{default: 1'b0};
         case (mode_r)
            SMCG_MODE_IDLE: begin
               clk_nxt.io        = 1'b1;
               clk_nxt.adc       = 1'b1;
               clk_nxt.asy       = 1'b1;
               clk_nxt.main_osc  = 1'b1;
               clk_nxt.timer_osc = async_timer_clock_select_r;
            end
            SMCG_MODE_ADCNR: begin
               clk_nxt.adc       = 1'b1;
               clk_nxt.asy       = 1'b1;
               clk_nxt.main_osc  = 1'b1;
               clk_nxt.timer_osc = async_timer_clock_select_r;
            end
            SMCG_MODE_PSAVE: begin
               clk_nxt.asy       = async_timer_clock_select_r;
               clk_nxt.timer_osc = async_timer_clock_select_r;
            end
            SMCG_MODE_STBY: begin
               clk_nxt.main_osc  = 1'b1;
            end
            SMCG_MODE_XSTBY: begin
               clk_nxt.main_osc  = 1'b1;
               clk_nxt.asy       = async_timer_clock_select_r;
               clk_nxt.timer_osc = async_timer_clock_select_r;
            end
            default: begin
               clk_nxt.main_osc  = 1'b0; // Power-down keeps no clock except main_osc while debug is live.
            end
         endcase
         if (debug_active) begin
            clk_nxt.main_osc = 1'b1;
         end
      end
   end

   // Per-mode wake sources while asleep.
   always_comb begin
      wake_ok = '{default: 1'b0};
      case (mode_r)
         SMCG_MODE_IDLE: wake_ok = '{default: 1'b1};
         SMCG_MODE_ADCNR: begin
            wake_ok = '{default: 1'b1};
            wake_ok.other_io = 1'b0;
         end
         SMCG_MODE_PSAVE, SMCG_MODE_XSTBY: begin
            wake_ok.ext_int   = 1'b1;
            wake_ok.twi_match = 1'b1;
            wake_ok.timer0    = async_timer_clock_select_r;
         end
         default: begin
            wake_ok.ext_int   = 1'b1;
            wake_ok.twi_match = 1'b1;
         end
      endcase
   end

   // Outside Idle only lines 3:0 and level-mode lines 7:4 count.
   always_comb begin
      wake_pin_nxt = 8'hff;
      if (in_sleep && (mode_r != SMCG_MODE_IDLE)) begin
         wake_pin_nxt = {ext_level_mode, 4'hf};
      end
   end

   assign wake_any = |(external_interrupt_lines & wake_pin_nxt & {8{wake_ok.ext_int}})
                     | |({wake_evt.twi_match, wake_evt.timer0, wake_evt.spm_ee,
                          wake_evt.adc, wake_evt.other_io}
                         & {wake_ok.twi_match, wake_ok.timer0, wake_ok.spm_ee,
                            wake_ok.adc, wake_ok.other_io});

   // ==========================================================
   // Sleep sequencer: sleep, start-up, four-cycle halt, then run.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= SMCG_RUN;
         mode_r  <= SMCG_MODE_IDLE;
         cnt_r   <= 8'h00;
      end else begin
         case (state_r)
            SMCG_RUN: begin
               if (sleep_req && mcu_control_reg_r[SMCG_BIT_SE] && mode_ok) begin
                  state_r <= SMCG_SLEEP;
                  mode_r  <= sel_mode;
               end
            end
            SMCG_SLEEP: begin
               if (wake_any) begin
                  state_r <= SMCG_START;
                  cnt_r   <= stby_mode ? 8'(SMCG_STBY_WAKE_CYC)
                                       : 8'(STARTUP_CYC);
               end
            end
            SMCG_START: begin
               cnt_r <= cnt_r - SMCG_CNT_ONE;
               if (cnt_r == SMCG_CNT_ONE) begin
                  state_r <= SMCG_HALT;
                  cnt_r   <= 8'(SMCG_HALT_EXTRA);
               end
            end
            SMCG_HALT: begin
               cnt_r <= cnt_r - SMCG_CNT_ONE;
               if (cnt_r == SMCG_CNT_ONE) begin
                  state_r <= SMCG_RUN;
               end
            end
            default: state_r <= SMCG_RUN;
         endcase
      end
   end

   // ==========================================================
   // Registered outputs to clocks, analog blocks and pin buffers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk_en            <= '{default: 1'b1};
         core_halt         <= 1'b0;
         adc_run           <= 1'b0;
         adc_extended_conv <= 1'b0;
         adc_prev_r        <= 1'b0;
         comp_run          <= 1'b0;
         ref_enable        <= 1'b0;
         brownout_run      <= 1'b0;
         watchdog_run      <= 1'b0;
         input_buf_en      <= 1'b1;
         wake_pin_buf_en   <= 8'hff;
      end else begin
         clk_en       <= clk_nxt;
         core_halt    <= (state_r != SMCG_RUN);
         adc_run      <= adc_enable;
         adc_prev_r   <= adc_enable;
         if (adc_enable && !adc_prev_r) begin
            adc_extended_conv <= 1'b1;
         end else if (!adc_enable) begin
            adc_extended_conv <= adc_extended_conv;
         end else begin
            adc_extended_conv <= 1'b0;
         end
         comp_run     <= !comp_disable && (!in_sleep || mode_r == SMCG_MODE_IDLE
                                          || mode_r == SMCG_MODE_ADCNR);
         ref_enable   <= brownout_enable_fuse || adc_enable
                         || (comp_uses_ref && !comp_disable);
         brownout_run <= brownout_enable_fuse;
         watchdog_run <= watchdog_enable;
         input_buf_en <= clk_nxt.io || clk_nxt.adc;
         wake_pin_buf_en <= wake_pin_nxt;
      end
   end

   // ==========================================================
   // Checks on the sequencer and gating.
   AST_NO_SLEEP_WITHOUT_SE: assert property (@(posedge clk) disable iff (reset)
      (state_r == SMCG_RUN && sleep_req && !mcu_control_reg_r[SMCG_BIT_SE])
      |=> state_r == SMCG_RUN) else $error("Sleep entered without sleep enable.");

   sequence s_stby_wake;
      state_r == SMCG_SLEEP && stby_mode && wake_any;
   endsequence
   AST_STBY_WAKE_SIX: assert property (@(posedge clk) disable iff (reset)
      s_stby_wake |=> (state_r == SMCG_START) [*6] ##1 state_r == SMCG_HALT)
      else $error("Standby wake did not take six cycles.");

   AST_HALT_FOUR: assert property (@(posedge clk) disable iff (reset)
      (state_r == SMCG_START && $past(state_r) == SMCG_START && cnt_r == SMCG_CNT_ONE)
      |=> (state_r == SMCG_HALT) [*4] ##1 state_r == SMCG_RUN)
      else $error("Halt after start-up not four cycles.");

   AST_RESERVED_REFUSED: assert property (@(posedge clk) disable iff (reset)
      (state_r == SMCG_RUN && sleep_req && !mode_ok) |=> state_r == SMCG_RUN)
      else $error("Reserved or unavailable mode entered.");

   AST_PDOWN_GATES_ALL: assert property (@(posedge clk) disable iff (reset)
      (in_sleep && mode_r == SMCG_MODE_PDOWN && !debug_active) |=> clk_en == '0)
      else $error("Power-down left a clock running.");

   AST_STBY_MAIN_ON: assert property (@(posedge clk) disable iff (reset)
      (in_sleep && mode_r == SMCG_MODE_STBY)
      |=> clk_en.main_osc && !clk_en.io && !clk_en.cpu && !clk_en.asy)
      else $error("Standby gating wrong.");

   AST_DEBUG_MAIN: assert property (@(posedge clk) disable iff (reset)
      (in_sleep && debug_active) |=> clk_en.main_osc)
      else $error("Debug did not hold main clock.");

   AST_INBUF_OFF: assert property (@(posedge clk) disable iff (reset)
      (in_sleep && mode_r == SMCG_MODE_PSAVE) |=> !input_buf_en)
      else $error("Input buffers left on.");

   AST_COMP_OFF: assert property (@(posedge clk) disable iff (reset)
      (in_sleep && mode_r == SMCG_MODE_PDOWN) |=> !comp_run)
      else $error("Comparator not disabled in deep sleep.");

   AST_XSTBY_ASYNC: assert property (@(posedge clk) disable iff (reset)
      (in_sleep && mode_r == SMCG_MODE_XSTBY)
      |=> clk_en.asy == $past(async_timer_clock_select_r) && clk_en.main_osc)
      else $error("Extended standby async clock wrong.");

endmodule // smcg_sleep_ctrl
`default_nettype wire

// ===== smcg_core_model.sv
// Purpose: Processor core model issuing sleep instructions and interrupts.
// Assumes: Shares the controller clock; the bench tells it when to act.
// Notes:   A pending interrupt source is cleared by its handler after resume.
`timescale 1ns/1ps
`default_nettype none
module smcg_core_model #(
   parameter int REF_START = 4
) (
   // System.
   input  wire logic       clk,
   input  wire logic       reset,
   // Bench commands.
   input  wire logic       do_sleep,
   input  wire logic [7:0] int_set,
   // Controller side.
   input  wire logic       core_halt,
   input  wire logic       ref_enable,
   output var  logic       sleep_req,
   output var  logic [7:0] external_interrupt_lines,
   output var  logic       ref_usable
);
   logic       halt_d;
   logic [3:0] ref_cnt;
   // ==========================================================
   // Core behaviour: one-cycle sleep instruction, interrupt sources, reference use.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sleep_req                <= 1'b0;
         halt_d                   <= 1'b0;
         external_interrupt_lines <= 8'h00;
         ref_cnt                  <= 4'h0;
      end else begin
         sleep_req <= do_sleep;
         halt_d    <= core_halt;
         // The handler runs once the core resumes and clears its sources.
         if (halt_d && !core_halt) begin
            external_interrupt_lines <= 8'h00;
         end else begin
            external_interrupt_lines <= external_interrupt_lines | int_set;
         end
         // Software trusts the reference only after its start-up time.
         if (!ref_enable) begin
            ref_cnt <= 4'h0;
         end else if (ref_cnt != 4'(REF_START)) begin
            ref_cnt <= ref_cnt + 4'h1;
         end
      end
   end
   // The reference output is usable once the start-up count has run.
   assign ref_usable = ref_enable && (ref_cnt == 4'(REF_START));
endmodule  // smcg_core_model
`default_nettype wire

// ===== smcg_sleep_ctrl_tb.sv
// Purpose: Self-checking bench for the sleep mode clock gating controller.
// Assumes: Core model drives sleep requests and interrupt lines.
// Notes:   Start-up count is shortened to keep wake checks quick.
`timescale 1ns/1ps
`default_nettype none
module smcg_sleep_ctrl_tb;
   import smcg_pkg::*;
   localparam int SU = 2;
   typedef struct packed {
      logic [2:0] m;
      logic as0, xt, dbg, scan_port_disable_bit, se, ok;
      logic [7:0] tl;
      logic [5:0] te;
      logic tw;
   } smcg_scn_type;
   // Mode, flags, trial lines, trial events, trial expected to wake.
   localparam smcg_scn_type SCN [16] = '{
      {3'h0,6'b110011,8'h00,6'h01,1'b1}, {3'h1,6'b010011,8'h00,6'h01,1'b0},
      {3'h2,6'b011011,8'h20,6'h00,1'b0}, {3'h2,6'b011111,8'h40,6'h00,1'b1},
      {3'h3,6'b110011,8'h00,6'h08,1'b1}, {3'h3,6'b011011,8'h00,6'h08,1'b0},
      {3'h6,6'b011011,8'h00,6'h08,1'b0}, {3'h6,6'b110011,8'h00,6'h10,1'b1},
      {3'h7,6'b110011,8'h00,6'h08,1'b1}, {3'h7,6'b010011,8'h00,6'h08,1'b0},
      {3'h2,6'b011011,8'h00,6'h04,1'b0}, {3'h4,6'b010010,8'h00,6'h00,1'b0},
      {3'h5,6'b010010,8'h00,6'h00,1'b0}, {3'h6,6'b000010,8'h00,6'h00,1'b0},
      {3'h7,6'b000010,8'h00,6'h00,1'b0}, {3'h0,6'b010000,8'h00,6'h00,1'b0}};
   // ==========================================================
   // Signals.
   logic          clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]    reg_addr = 4'h0;
   logic [7:0]    reg_wdata = 8'h00, reg_rdata, int_set = 8'h00, external_interrupt_lines;
   logic          sleep_req, core_halt, do_sleep = 1'b0, ref_usable;
   logic          ext_crystal_sel = 1'b1, brownout_enable_fuse = 1'b0;
   logic          debug_enable_fuse = 1'b0, scan_port_enable_fuse = 1'b0;
   logic          adc_enable = 1'b0, comp_disable = 1'b0, comp_uses_ref = 1'b0;
   logic          watchdog_enable = 1'b0, adc_run, adc_extended_conv, comp_run;
   logic          ref_enable, brownout_run, watchdog_run, input_buf_en;
   logic [7:4]    ext_level_mode = 4'h4;
   logic [7:0]    wake_pin_buf_en;
   smcg_wake_type wake_evt = '0;
   smcg_clk_type  clk_en;
   logic          rd_d = 1'b0, halt_d = 1'b0, hung = 1'b0;
   logic [2:0]    last_m = 3'h0;
   logic [31:0]   seed = 32'h0000002c;
   logic [7:0]    rd_q [$];
   logic [20:0]   sl_q [$];
   int            bad_count = 0, comparisons = 0;
   // ==========================================================
   // Design, core model and clock.
   smcg_sleep_ctrl #(.STARTUP_CYC(SU)) i_smcg_sleep_ctrl (.clk, .reset, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_req, .core_halt, .ext_crystal_sel,
      .brownout_enable_fuse, .debug_enable_fuse, .scan_port_enable_fuse, .adc_enable,
      .comp_disable, .comp_uses_ref, .watchdog_enable, .external_interrupt_lines,
      .ext_level_mode, .wake_evt, .clk_en, .adc_run, .adc_extended_conv, .comp_run,
      .ref_enable, .brownout_run, .watchdog_run, .input_buf_en, .wake_pin_buf_en);
   smcg_core_model i_smcg_core_model (.clk, .reset, .do_sleep, .int_set, .core_halt,
      .ref_enable, .sleep_req, .external_interrupt_lines, .ref_usable);
   always #5 clk = ~clk;
   // ==========================================================
   // Checking helpers.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Expected gated outputs for one sleep mode.
   function automatic logic [20:0] exp_sleep(input logic [2:0] m, input logic a, input logic d);
      smcg_clk_type c;
      case (m)
         SMCG_MODE_IDLE:  c = {5'h07, 1'b1, a};
         SMCG_MODE_ADCNR: c = {5'h03, 1'b1, a};
         SMCG_MODE_PSAVE: c = {4'h0, a, 1'b0, a};
         SMCG_MODE_STBY:  c = 7'h02;
         SMCG_MODE_XSTBY: c = {4'h0, a, 1'b1, a};
         default:         c = 7'h00;
      endcase
      c.main_osc = c.main_osc | d;
      return {c, c.io | c.adc, !comp_disable && m < 3'h2,
              brownout_enable_fuse | adc_enable | (comp_uses_ref & !comp_disable),
              brownout_enable_fuse, watchdog_enable, adc_enable,
              (m == SMCG_MODE_IDLE) ? 8'hff : {ext_level_mode, 4'hf}};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Register bus master tasks.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask
   // Counts edges until the core resumes, bounded at 20.
   task automatic wt(output int c);
      c = 0;
      do begin
         @(posedge clk);
         int_set <= 8'h00;
         c++;
      end while (core_halt === 1'b1 && c < 20);
   endtask
   // ==========================================================
   // One sleep episode: configure, sleep, trial wake, final wake.
   task automatic run(input smcg_scn_type s);
      int n, c;
      seed = xs(seed);
      @(posedge clk);
      {adc_enable, comp_disable, comp_uses_ref, watchdog_enable} <= seed[3:0];
      brownout_enable_fuse  <= seed[4];
      scan_port_enable_fuse <= seed[5];
      debug_enable_fuse     <= s.dbg;
      ext_crystal_sel       <= s.xt;
      wr(SMCG_OFS_ASYNC_STAT, {4'h0, s.as0, 3'h0});
      wr(SMCG_OFS_MCU_CSR, {s.scan_port_disable_bit, 7'h00});
      wr(SMCG_OFS_MCU_CTRL, {2'b00, s.se, s.m, 2'b00});
      if (s.ok) sl_q.push_back(exp_sleep(s.m, s.as0, s.dbg & seed[5] & !s.scan_port_disable_bit));
      // The status byte keeps the mode of the last sleep that was accepted.
      if (s.ok) last_m = s.m;
      @(posedge clk);
      do_sleep <= 1'b1;
      @(posedge clk);
      do_sleep <= 1'b0;
      repeat (4) @(posedge clk);
      rd(SMCG_OFS_STATUS, {3'h0, last_m, 1'b0, s.ok});
      chk(ref_usable,
          brownout_enable_fuse | adc_enable | (comp_uses_ref & !comp_disable));
      if (!s.ok) begin
         chk(core_halt, 0);
         chk(clk_en, 7'h7f);
         return;
      end
      n = s.m[2] ? SMCG_STBY_WAKE_CYC : SU;
      int_set  <= s.tl;
      wake_evt <= s.te;
      wt(c);
      chk(c, s.tw ? n + ((s.tl != 8'h00) ? 8 : 7) : 20);
      // A wake that never came leaves the core halted, so the run stops here.
      if (s.tw && c == 20) hung = 1'b1;
      if (!s.tw) begin
         @(posedge clk);
         wake_evt <= '0;
         int_set  <= 8'h01;
         wt(c);
         chk(c, n + 8);
         if (c == 20) hung = 1'b1;
      end
      wake_evt <= '0;
   endtask
   // ==========================================================
   // Watcher: pops the oldest note whenever a result appears.
   always @(posedge clk) begin
      if (rd_d) chk(reg_rdata, rd_q.pop_front());
      if (core_halt && !halt_d && sl_q.size() == 0) chk(core_halt, 0);
      else if (core_halt && !halt_d) chk({clk_en, input_buf_en, comp_run, ref_enable,
         brownout_run, watchdog_run, adc_run, wake_pin_buf_en}, sl_q.pop_front());
      if (!core_halt && halt_d) chk(clk_en, 7'h7f);
      rd_d   <= reg_rd;
      halt_d <= core_halt;
   end
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 4; a++) rd(4'(a), SMCG_RESET_BYTE);
      rd(4'h9, 8'h00);
      wr(SMCG_OFS_STATUS, 8'hff);
      wr(SMCG_OFS_MCU_CTRL, 8'h3c);
      rd(SMCG_OFS_MCU_CTRL, 8'h3c);
      rd(SMCG_OFS_STATUS, 8'h00);
      @(posedge clk);
      adc_enable <= 1'b1;
      repeat (3) @(posedge clk);
      adc_enable <= 1'b0;
      repeat (3) @(posedge clk);
      adc_enable <= 1'b1;
      repeat (2) @(posedge clk);
      chk(adc_extended_conv, 1);
      @(posedge clk);
      chk(adc_extended_conv, 0);
      chk(adc_run, 1);
      foreach (SCN[i]) if (!hung) run(SCN[i]);
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule  // smcg_sleep_ctrl_tb
`default_nettype wire
